// *** hdl/mstk_pkg.sv ***
package mstk_pkg;

  // Privilege mode encodings
  localparam logic [1:0] MODE_USER = 2'h0;
  localparam logic [1:0] MODE_SUPER = 2'h1;
  localparam logic [1:0] MODE_HYPER = 2'h2;
  localparam logic [1:0] MODE_MACHINE = 2'h3;

  // Register select codes on the access port
  localparam logic [1:0] SEL_ARCH = 2'h0;
  localparam logic [1:0] SEL_IMPL = 2'h1;
  localparam logic [1:0] SEL_THREAD = 2'h2;
  localparam logic [1:0] SEL_STATUS = 2'h3;

  // Status field positions
  localparam int POS_UIE = 0;
  localparam int POS_SIE = 1;
  localparam int POS_HIE = 2;
  localparam int POS_MIE = 3;
  localparam int POS_USER_PRIOR_ENABLE = 4;
  localparam int POS_SUPER_PRIOR_ENABLE = 5;
  localparam int POS_HYPER_PRIOR_ENABLE = 6;
  localparam int POS_MACHINE_PRIOR_ENABLE = 7;
  localparam int POS_SPP = 8;
  localparam int POS_HPP_LO = 9;
  localparam int POS_MPP_LO = 11;
  localparam int POS_FS_LO = 13;
  localparam int POS_XS_LO = 15;
  localparam int POS_MODIFY_PRIVILEGE = 17;
  localparam int POS_PUM = 18;
  localparam int POS_MXR = 19;
  localparam int POS_VM_LO = 24;
  localparam int VM_WIDTH = 5;

  // Reset values
  localparam logic [4:0] VM_RESET = 5'h00;
  localparam logic [1:0] FS_RESET = 2'h0;

  // Stack state of the status register
  typedef struct packed {
    logic [1:0] machine_prior_mode;
    logic [1:0] hyper_prior_mode;
    logic super_prior_mode;
    logic [3:0] prior_enable;
    logic [3:0] int_enable;
  } mstk_stack_type;

  // Trap event from the hart
  typedef struct packed {
    logic valid;
    logic [1:0] from_mode;
    logic [1:0] to_mode;
  } mstk_trap_type;

endpackage : mstk_pkg

// *** hdl/mstk_status.sv ***
`timescale 1ns/1ps
module mstk_status #(
  parameter int XLEN = 32,
  parameter logic [XLEN-1:0] ARCH_ID = '0, // Arbitrary value, zero means absent
  parameter logic [XLEN-1:0] IMPL_ID = '0, // Arbitrary value, zero means absent
  parameter logic [XLEN-1:0] VENDOR_ID = '0, // Arbitrary value, zero means absent
  parameter bit HAS_USER = 1'b1,
  parameter bit HAS_SUPER = 1'b1,
  parameter bit HAS_HYPER = 1'b0,
  parameter bit HAS_USER_INT = 1'b0,
  parameter bit HAS_FLOAT = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [XLEN-1:0] thread_number_i,
  input wire logic [1:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic [XLEN-1:0] reg_wdata_i,
  input wire mstk_pkg::mstk_trap_type trap_i,
  input wire logic ret_valid_i,
  input wire logic [1:0] ret_mode_i,
  input wire logic [3:0] int_pending_i,
  output logic [XLEN-1:0] reg_rdata_o,
  output logic [XLEN-1:0] vendor_id_o,
  output logic [1:0] cur_mode_o,
  output logic [3:0] int_accept_o
);

  localparam logic [1:0] LOWEST = HAS_USER ? mstk_pkg::MODE_USER : mstk_pkg::MODE_MACHINE;
  // Enable bits that exist; user bits only with user interrupts
  localparam logic [3:0] KEEP_MASK = {1'b1, HAS_HYPER, HAS_SUPER, HAS_USER_INT};

  mstk_pkg::mstk_stack_type stk_r;
  mstk_pkg::mstk_stack_type stk_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [4:0] vm_r;
  logic [1:0] fs_r;
  logic modify_privilege_r;
  logic pum_r;
  logic mxr_r;
  logic [XLEN-1:0] status_view;
  logic [XLEN-1:0] reg_rdata_r;
  logic [3:0] accept_r;
  logic [XLEN-1:0] thread_r;
  logic [3:0] mode_ok;

  assign mode_ok = {1'b1, HAS_HYPER, HAS_SUPER, HAS_USER};

  // Legalise a prior-mode value to a supported mode at most the field's level
  function automatic logic [1:0] legal_mode(input logic [1:0] m, input logic [1:0] cap);
    logic [1:0] r;
    r = (m > cap) ? cap : m;
    if (r == mstk_pkg::MODE_HYPER && !HAS_HYPER)
      r = mstk_pkg::MODE_MACHINE;
    if (r == mstk_pkg::MODE_SUPER && !HAS_SUPER)
      r = HAS_USER ? mstk_pkg::MODE_USER : mstk_pkg::MODE_MACHINE;
    if (r == mstk_pkg::MODE_USER && !HAS_USER)
      r = mstk_pkg::MODE_MACHINE;
    if (r > cap)
      r = cap;
    return r;
  endfunction : legal_mode

  // Drop enable bits of modes that are not implemented, and user bits without user interrupts
  function automatic logic [3:0] keep_bits(input logic [3:0] b);
    logic [3:0] r;
    r = b & {1'b1, HAS_HYPER, HAS_SUPER, HAS_USER_INT};
    return r;
  endfunction : keep_bits

  // Next stack state: write, trap entry, trap return
  always_comb
  begin
    stk_nxt = stk_r;
    mode_nxt = mode_r;
    if (reg_wr_i && reg_sel_i == mstk_pkg::SEL_STATUS)
    begin
      stk_nxt.int_enable = keep_bits(reg_wdata_i[mstk_pkg::POS_MIE:mstk_pkg::POS_UIE]);
      stk_nxt.prior_enable = keep_bits(reg_wdata_i[mstk_pkg::POS_MACHINE_PRIOR_ENABLE:mstk_pkg::POS_USER_PRIOR_ENABLE]);
      stk_nxt.super_prior_mode = HAS_SUPER && HAS_USER && reg_wdata_i[mstk_pkg::POS_SPP];
      stk_nxt.hyper_prior_mode = HAS_HYPER ? legal_mode(reg_wdata_i[mstk_pkg::POS_HPP_LO+:2],
                                                        mstk_pkg::MODE_HYPER) : 2'h0;
      stk_nxt.machine_prior_mode = legal_mode(reg_wdata_i[mstk_pkg::POS_MPP_LO+:2],
                                              mstk_pkg::MODE_MACHINE);
    end
    if (trap_i.valid)
    begin
      // Push: prior enable takes source enable, target enable clears
      stk_nxt.prior_enable[trap_i.to_mode] = stk_r.int_enable[trap_i.from_mode]
        & KEEP_MASK[trap_i.to_mode];
      stk_nxt.int_enable[trap_i.to_mode] = 1'b0;
      case (trap_i.to_mode)
        mstk_pkg::MODE_MACHINE: stk_nxt.machine_prior_mode = legal_mode(trap_i.from_mode, mstk_pkg::MODE_MACHINE);
        mstk_pkg::MODE_HYPER: stk_nxt.hyper_prior_mode = legal_mode(trap_i.from_mode, mstk_pkg::MODE_HYPER);
        mstk_pkg::MODE_SUPER: stk_nxt.super_prior_mode = trap_i.from_mode[0];
        default: ;
      endcase
      mode_nxt = trap_i.to_mode;
    end
    else if (ret_valid_i)
    begin
      // Pop the stack of the returning mode
      case (ret_mode_i)
        mstk_pkg::MODE_MACHINE:
        begin
          mode_nxt = stk_r.machine_prior_mode;
          stk_nxt.machine_prior_mode = LOWEST;
        end
        mstk_pkg::MODE_HYPER:
        begin
          mode_nxt = stk_r.hyper_prior_mode;
          stk_nxt.hyper_prior_mode = HAS_HYPER ? LOWEST : 2'h0;
        end
        mstk_pkg::MODE_SUPER:
        begin
          mode_nxt = {1'b0, stk_r.super_prior_mode};
          stk_nxt.super_prior_mode = 1'b0;
        end
        default: mode_nxt = mstk_pkg::MODE_USER;
      endcase
      stk_nxt.int_enable[mode_nxt] = stk_r.prior_enable[ret_mode_i] & KEEP_MASK[mode_nxt];
      stk_nxt.prior_enable[ret_mode_i] = KEEP_MASK[ret_mode_i];
    end
  end

  // Stack and current mode
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stk_r <= '{machine_prior_mode: mstk_pkg::MODE_MACHINE, default: '0};
      mode_r <= mstk_pkg::MODE_MACHINE;
    end
    else if (clk_en_i)
    begin
      stk_r <= stk_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Memory and extension fields written by software
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      vm_r <= mstk_pkg::VM_RESET;
      fs_r <= mstk_pkg::FS_RESET;
      modify_privilege_r <= 1'b0;
      pum_r <= 1'b0;
      mxr_r <= 1'b0;
    end
    else if (clk_en_i && reg_wr_i && reg_sel_i == mstk_pkg::SEL_STATUS)
    begin
      vm_r <= mstk_pkg::VM_RESET; // Only bare scheme supported
      fs_r <= (HAS_SUPER || HAS_FLOAT) ? reg_wdata_i[mstk_pkg::POS_FS_LO+:2] : 2'h0;
      modify_privilege_r <= reg_wdata_i[mstk_pkg::POS_MODIFY_PRIVILEGE];
      pum_r <= HAS_SUPER && reg_wdata_i[mstk_pkg::POS_PUM];
      mxr_r <= HAS_SUPER && reg_wdata_i[mstk_pkg::POS_MXR];
    end
  end

  // Assemble the status view; reserved bits stay zero
  always_comb
  begin
    status_view = '0;
    status_view[mstk_pkg::POS_MIE:mstk_pkg::POS_UIE] = stk_r.int_enable;
    status_view[mstk_pkg::POS_MACHINE_PRIOR_ENABLE:mstk_pkg::POS_USER_PRIOR_ENABLE] = stk_r.prior_enable;
    status_view[mstk_pkg::POS_SPP] = stk_r.super_prior_mode;
    status_view[mstk_pkg::POS_HPP_LO+:2] = stk_r.hyper_prior_mode;
    status_view[mstk_pkg::POS_MPP_LO+:2] = stk_r.machine_prior_mode;
    status_view[mstk_pkg::POS_FS_LO+:2] = fs_r;
    status_view[mstk_pkg::POS_XS_LO+:2] = 2'h0; // No extra extension state
    status_view[mstk_pkg::POS_MODIFY_PRIVILEGE] = modify_privilege_r;
    status_view[mstk_pkg::POS_PUM] = pum_r;
    status_view[mstk_pkg::POS_MXR] = mxr_r;
    status_view[mstk_pkg::POS_VM_LO+:mstk_pkg::VM_WIDTH] = vm_r;
    status_view[XLEN-1] = (fs_r == 2'h3);
  end

  // Thread number sampled on every enabled cycle, during reset too; identifier set by the system
  always_ff @(posedge clk_i)
  begin
    if (clk_en_i)
      thread_r <= thread_number_i;
  end

  // Registered read data
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_r <= '0;
    else if (clk_en_i)
    begin
      case (reg_sel_i)
        mstk_pkg::SEL_ARCH: reg_rdata_r <= ARCH_ID;
        mstk_pkg::SEL_IMPL: reg_rdata_r <= IMPL_ID;
        mstk_pkg::SEL_THREAD: reg_rdata_r <= thread_r;
        mstk_pkg::SEL_STATUS: reg_rdata_r <= status_view;
        default: reg_rdata_r <= '0;
      endcase
    end
  end

  // Interrupt acceptance by privilege
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      accept_r <= 4'h0;
    else if (clk_en_i)
    begin
      for (int m = 0; m < 4; m++)
        accept_r[m] <= int_pending_i[m] && mode_ok[m]
          && ((m > mode_r) || (m == mode_r && stk_r.int_enable[m]));
    end
  end

  assign reg_rdata_o = reg_rdata_r;
  assign cur_mode_o = mode_r;
  assign int_accept_o = accept_r;

  // Vendor id as a constant register
  always_ff @(posedge clk_i)
  begin
    vendor_id_o <= VENDOR_ID;
  end

  chk_trap_clears_enable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && trap_i.valid |=> !stk_r.int_enable[$past(trap_i.to_mode)])
    else $error("trap did not clear target enable");

  chk_trap_sets_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && trap_i.valid |=> mode_r == $past(trap_i.to_mode))
    else $error("trap did not switch mode");

  chk_machine_trap_return_prior_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && ret_valid_i && !trap_i.valid && ret_mode_i == mstk_pkg::MODE_MACHINE
    |=> stk_r.prior_enable[3] && stk_r.machine_prior_mode == LOWEST)
    else $error("machine return did not reset stack");

  chk_machine_trap_return_mode: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && ret_valid_i && !trap_i.valid && ret_mode_i == mstk_pkg::MODE_MACHINE
    |=> mode_r == $past(stk_r.machine_prior_mode))
    else $error("machine return went to wrong mode");

  chk_lower_blocked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_r == mstk_pkg::MODE_MACHINE && $stable(mode_r) |=> int_accept_o[2:0] == 3'h0)
    else $error("lower mode interrupt accepted");

  chk_user_int_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !HAS_USER_INT |-> !stk_r.int_enable[0] && !stk_r.prior_enable[0])
    else $error("user enable bits not zero");

  chk_mpp_legal: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    mode_ok[stk_r.machine_prior_mode])
    else $error("machine prior mode illegal");

  chk_hyper_absent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !HAS_HYPER |-> stk_r.hyper_prior_mode == 2'h0 && !stk_r.int_enable[2] && !stk_r.prior_enable[2])
    else $error("absent hyper fields not zero");

  chk_status_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    clk_en_i && reg_sel_i == mstk_pkg::SEL_STATUS
    |=> reg_rdata_o[23:20] == 4'h0 && reg_rdata_o[mstk_pkg::POS_MIE] == $past(stk_r.int_enable[3]))
    else $error("status read wrong");

endmodule : mstk_status

// *** bench/mstk_hart_model.sv ***
`timescale 1ns/1ps
module mstk_hart_model (
  input wire logic clk_i,
  input wire logic trap_go_i,
  input wire logic ret_go_i,
  input wire logic [1:0] fm_i,
  input wire logic [1:0] tm_i,
  output mstk_pkg::mstk_trap_type trap_o,
  output logic ret_valid_o,
  output logic [1:0] ret_mode_o
);
  logic [1:0] idle_r = 2'h1;

  // Idle pattern so stale mode fields never hold a steady value
  always @(posedge clk_i)
    idle_r <= idle_r + 2'h1;

  // One-cycle trap and return pulses, the bench spaces them
  assign trap_o.valid = trap_go_i;
  assign trap_o.from_mode = trap_go_i ? fm_i : idle_r;
  assign trap_o.to_mode = trap_go_i ? tm_i : ~idle_r;
  assign ret_valid_o = ret_go_i;
  assign ret_mode_o = ret_go_i ? tm_i : idle_r;
endmodule : mstk_hart_model

// *** bench/machine_status_trap_stack_test.sv ***
`timescale 1ns/1ps
module machine_status_trap_stack_test;
  localparam logic [31:0] ARCH = 32'h8000_0123; // Arbitrary value
  localparam logic [31:0] IMPL = 32'h1200_0000; // Arbitrary value
  localparam logic [31:0] VEND = 32'h0000_0A5C; // Arbitrary value
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [1:0] reg_sel_i = 2'h0;
  logic reg_wr_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] thread_number_i = 32'h0000_0007;
  logic trap_go = 1'b0;
  logic ret_go = 1'b0;
  logic [1:0] fm = 2'h0;
  logic [1:0] tm = 2'h0;
  logic [3:0] int_pending_i = 4'hF;
  mstk_pkg::mstk_trap_type trap_i;
  logic ret_valid_i;
  logic [1:0] ret_mode_i;
  logic [31:0] reg_rdata_o;
  logic [31:0] vendor_id_o;
  logic [1:0] cur_mode_o;
  logic [3:0] int_accept_o;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // Clock and hang guard
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      close_out();
    end
  end

  mstk_hart_model i_hart (.clk_i(clk_i), .trap_go_i(trap_go), .ret_go_i(ret_go), .fm_i(fm), .tm_i(tm),
    .trap_o(trap_i), .ret_valid_o(ret_valid_i), .ret_mode_o(ret_mode_i));

  mstk_status #(.XLEN(32), .ARCH_ID(ARCH), .IMPL_ID(IMPL), .VENDOR_ID(VEND)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .thread_number_i(thread_number_i),
    .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .trap_i(trap_i),
    .ret_valid_i(ret_valid_i), .ret_mode_i(ret_mode_i), .int_pending_i(int_pending_i),
    .reg_rdata_o(reg_rdata_o), .vendor_id_o(vendor_id_o), .cur_mode_o(cur_mode_o),
    .int_accept_o(int_accept_o));

  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Select, wait for registered data, compare
  task automatic read_reg(input logic [1:0] sel, input logic [31:0] exp);
    @(posedge clk_i);
    reg_sel_i <= sel;
    repeat (2) @(posedge clk_i);
    #1;
    check(reg_rdata_o, exp);
  endtask : read_reg

  // One-cycle write strobe
  task automatic write_reg(input logic [1:0] sel, input logic [31:0] val);
    @(posedge clk_i);
    reg_sel_i <= sel;
    reg_wr_i <= 1'b1;
    reg_wdata_i <= val;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : write_reg

  // Trap entry or return through the hart model
  task automatic pulse(input logic is_trap, input logic [1:0] f, input logic [1:0] t);
    @(posedge clk_i);
    trap_go <= is_trap;
    ret_go <= !is_trap;
    fm <= f;
    tm <= t;
    @(posedge clk_i);
    trap_go <= 1'b0;
    ret_go <= 1'b0;
  endtask : pulse

  // Status word, mode and accepted interrupts
  task automatic expect_state(input logic [31:0] st, input logic [1:0] md, input logic [3:0] acc);
    read_reg(mstk_pkg::SEL_STATUS, st);
    check({30'h0, cur_mode_o}, {30'h0, md});
    check({28'h0, int_accept_o}, {28'h0, acc});
  endtask : expect_state

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    expect_state(32'h0000_1800, 2'h3, 4'h0);
    read_reg(mstk_pkg::SEL_ARCH, ARCH);
    read_reg(mstk_pkg::SEL_IMPL, IMPL);
    read_reg(mstk_pkg::SEL_THREAD, 32'h0000_0007);
    check(vendor_id_o, VEND);
    write_reg(mstk_pkg::SEL_ARCH, 32'h0000_0000);
    read_reg(mstk_pkg::SEL_ARCH, ARCH);
    write_reg(mstk_pkg::SEL_STATUS, 32'h60F0_1FFF);
    expect_state(32'h0000_19AA, 2'h3, 4'h8);
    write_reg(mstk_pkg::SEL_STATUS, 32'h0000_0800);
    expect_state(32'h0000_0800, 2'h3, 4'h0);
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    write_reg(mstk_pkg::SEL_STATUS, 32'h0000_0008);
    clk_en_i <= 1'b1;
    expect_state(32'h0000_0800, 2'h3, 4'h0);
    write_reg(mstk_pkg::SEL_STATUS, 32'h0000_0080);
    pulse(1'b0, 2'h0, mstk_pkg::MODE_MACHINE);
    expect_state(32'h0000_0080, 2'h0, 4'hA);
    pulse(1'b1, mstk_pkg::MODE_USER, mstk_pkg::MODE_SUPER);
    expect_state(32'h0000_0080, 2'h1, 4'h8);
    write_reg(mstk_pkg::SEL_STATUS, 32'h0000_00A2);
    expect_state(32'h0000_00A2, 2'h1, 4'hA);
    pulse(1'b1, mstk_pkg::MODE_SUPER, mstk_pkg::MODE_MACHINE);
    expect_state(32'h0000_08A2, 2'h3, 4'h0);
    pulse(1'b0, 2'h0, mstk_pkg::MODE_MACHINE);
    expect_state(32'h0000_00A2, 2'h1, 4'hA);
    pulse(1'b0, 2'h0, mstk_pkg::MODE_SUPER);
    expect_state(32'h0000_00A2, 2'h0, 4'hA);
    pulse(1'b1, mstk_pkg::MODE_USER, mstk_pkg::MODE_MACHINE);
    expect_state(32'h0000_0022, 2'h3, 4'h0);
    close_out();
  end
endmodule : machine_status_trap_stack_test
